// [logic/spp_divider.sv]
// restoring divider, one quotient bit per cycle
module spp_divider (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic start_i,
  input wire logic [spp_pkg::DIV_W-1:0] num_i,
  input wire logic [spp_pkg::DIV_W-1:0] den_i,
  output logic busy_o,
  output logic done_o,
  output logic [spp_pkg::DIV_W-1:0] quo_o
);
  localparam int unsigned W = spp_pkg::DIV_W;
  logic [W-1:0] rem_ff, nxt_rem, quo_ff, nxt_quo, den_ff, nxt_den;
  logic [6:0] cnt_ff, nxt_cnt;
  logic [W:0] trial;

  assign busy_o = cnt_ff != 7'h00;
  assign done_o = cnt_ff == 7'h01;
  assign quo_o = nxt_quo;

  // divisor is latched so a config write mid-run cannot corrupt the result
  always_comb begin
    nxt_rem = rem_ff;
    nxt_quo = quo_ff;
    nxt_den = den_ff;
    nxt_cnt = cnt_ff;
    trial = {rem_ff, quo_ff[W-1]} - {1'b0, den_ff};
    if (busy_o) begin
      nxt_cnt = cnt_ff - 7'h01;
      if (!trial[W]) begin
        nxt_rem = trial[W-1:0];
        nxt_quo = {quo_ff[W-2:0], 1'b1};
      end else begin
        nxt_rem = {rem_ff[W-2:0], quo_ff[W-1]};
        nxt_quo = {quo_ff[W-2:0], 1'b0};
      end
    end else if (start_i) begin
      nxt_rem = '0;
      nxt_quo = num_i;
      nxt_den = den_i;
      nxt_cnt = 7'(W);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      rem_ff <= '0;
      quo_ff <= '0;
      den_ff <= '0;
      cnt_ff <= 7'h00;
    end else begin
      rem_ff <= nxt_rem;
      quo_ff <= nxt_quo;
      den_ff <= nxt_den;
      cnt_ff <= nxt_cnt;
    end
  end
endmodule // spp_divider

// [logic/spp_pacer.sv]
// Notes on behaviour
// R1: frame size register is image bytes plus chunk bytes if enabled, no headers.
// R2: channel selector picks which stream channel takes parameter writes.
// R3: only stream channel zero exists.
// R4: each frame is one leader, one or more payloads, one trailer.
// R5: packet length sizes payload packets only; last payload may be short.
// R6: payload bytes per packet are packet length minus 36.
// R7: a programmable gap in 8 ns ticks separates successive packets.
// R8: tick frequency register reads ticks per second.
// R9: frame start is held off by a programmed number of 8 ns ticks.
// R10: host normally keeps hold-off zero; nonzero only to stagger cameras.
// R11: assigned rate in bytes per second derives from packet length and gap.
// R12: one byte on the link takes exactly one tick.
// R13: reserve percentage of bandwidth sets resends allowed per frame period.
// R14: pool capacity is multiplier times reserve resends per period.
// R15: the resend pool starts full.
// R16: unused reserve is credited after each period, overuse drawn from pool.
// R17: idle periods still credit their reserve resends, up to capacity.
// R18: resends beyond reserve and pool get a packet-unavailable answer.
// R19: host sets packet length to the largest its path can carry.
// R20: host packet timeout must exceed the inter-packet gap.
// R21: resend counters saturate at zero and at capacity.
//
// Our own choices: the placing of the registers and register access over AXI4-Lite.
module spp_pacer (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic frame_start_i,
  input wire logic [31:0] image_bytes_i,
  input wire logic [31:0] chunk_bytes_i,
  output logic pkt_valid_o,
  input wire logic pkt_ready_i,
  output logic [1:0] pkt_kind_o,
  output logic [15:0] pkt_bytes_o,
  output logic frame_busy_o,
  input wire logic resend_req_i,
  output logic resend_grant_o,
  output logic resend_unavail_o
);
  localparam int unsigned W = spp_pkg::DIV_W;
  logic bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
  logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [15:0] pkt_len_ff, nxt_pkt_len, mult_ff, nxt_mult;
  logic [31:0] gap_ff, nxt_gap, holdoff_ff, nxt_holdoff, frame_bytes_ff;
  logic [7:0] reserve_ff, nxt_reserve;
  logic chunk_en_ff, nxt_chunk_en, wr_go, rd_go;
  logic [31:0] wr_val, rd_val;
  logic [7:0] chan_sel_ff;
  spp_pkg::spp_state_e state_ff, nxt_state;
  logic [1:0] kind_ff, nxt_kind;
  logic [15:0] bytes_ff, nxt_bytes, chunk;
  logic [31:0] remain_ff, nxt_remain, pkts_ff, nxt_pkts, last_pkts_ff, nxt_last_pkts;
  logic [31:0] period_ff, nxt_period, idle_ff, nxt_idle, run_ff, nxt_run;
  logic timer_start, timer_done, accept, hs, frame_done, idle_credit;
  logic rate_busy, rate_done, res_busy, res_done;
  logic [W-1:0] rate_q, res_q;
  logic [31:0] rate_ff, resv_ff, cap_ff, pool_ff, nxt_pool, used_ff, nxt_used;
  logic pool_init_ff, nxt_pool_init, grant_ff, nxt_grant, unav_ff, nxt_unav;
  logic [32:0] credit;

  // only channel zero exists, so the selector is fixed at zero
  // R3: single channel zero
  assign chan_sel_ff = 8'h00;
  assign wr_go = s_axi_awvalid_i && s_axi_wvalid_i && !bvalid_ff;
  assign rd_go = s_axi_arvalid_i && !rvalid_ff;
  assign s_axi_awready_o = wr_go;
  assign s_axi_wready_o = wr_go;
  assign s_axi_arready_o = rd_go;
  assign s_axi_bvalid_o = bvalid_ff;
  assign s_axi_bresp_o = bresp_ff;
  assign s_axi_rvalid_o = rvalid_ff;
  assign s_axi_rresp_o = rresp_ff;
  assign s_axi_rdata_o = rdata_ff;
  // R1: size excludes headers
  assign frame_bytes_ff = image_bytes_i + (chunk_en_ff ? chunk_bytes_i : 32'h00000000);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction

  // register writes; short packet lengths are refused so the payload never vanishes
  always_comb begin
    nxt_pkt_len = pkt_len_ff;
    nxt_gap = gap_ff;
    nxt_holdoff = holdoff_ff;
    nxt_reserve = reserve_ff;
    nxt_mult = mult_ff;
    nxt_chunk_en = chunk_en_ff;
    nxt_bvalid = bvalid_ff && !s_axi_bready_i;
    nxt_bresp = bresp_ff;
    wr_val = 32'h00000000;
    if (wr_go) begin
      nxt_bvalid = 1'b1;
      nxt_bresp = spp_pkg::RESP_OKAY;
      unique case (s_axi_awaddr_i)
        spp_pkg::OFS_CHAN_SEL: begin
          // R3: nonzero channel refused
          wr_val = merge(32'(chan_sel_ff), s_axi_wdata_i, s_axi_wstrb_i);
          if (wr_val != 32'h00000000) nxt_bresp = spp_pkg::RESP_SLVERR;
        end
        spp_pkg::OFS_PKT_LEN: begin
          wr_val = merge(32'(pkt_len_ff), s_axi_wdata_i, s_axi_wstrb_i);
          if (wr_val[31:16] != 16'h0000 || wr_val[15:0] < spp_pkg::PKT_LEN_MIN) begin
            nxt_bresp = spp_pkg::RESP_SLVERR;
          end else begin
            nxt_pkt_len = wr_val[15:0];
          end
        end
        // R2: stream writes land on the selected channel
        spp_pkg::OFS_PKT_GAP: nxt_gap = merge(gap_ff, s_axi_wdata_i, s_axi_wstrb_i);
        spp_pkg::OFS_HOLDOFF: nxt_holdoff = merge(holdoff_ff, s_axi_wdata_i, s_axi_wstrb_i);
        spp_pkg::OFS_RESERVE: begin
          wr_val = merge(32'(reserve_ff), s_axi_wdata_i, s_axi_wstrb_i);
          if (wr_val > 32'(spp_pkg::PCT_FULL)) nxt_bresp = spp_pkg::RESP_SLVERR;
          else nxt_reserve = wr_val[7:0];
        end
        spp_pkg::OFS_MULT: nxt_mult = merge(32'(mult_ff), s_axi_wdata_i, s_axi_wstrb_i) >> 0 > 32'h0000FFFF
          ? mult_ff : 16'(merge(32'(mult_ff), s_axi_wdata_i, s_axi_wstrb_i));
        spp_pkg::OFS_CTRL: begin
          wr_val = merge({31'h00000000, chunk_en_ff}, s_axi_wdata_i, s_axi_wstrb_i);
          nxt_chunk_en = wr_val[spp_pkg::CHUNK_EN_BIT];
        end
        default: nxt_bresp = spp_pkg::RESP_SLVERR;
      endcase
    end
  end

  // register reads; unmapped offsets answer SLVERR with zero data
  always_comb begin
    nxt_rvalid = rvalid_ff && !s_axi_rready_i;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    rd_val = 32'h00000000;
    if (rd_go) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = spp_pkg::RESP_OKAY;
      unique case (s_axi_araddr_i)
        spp_pkg::OFS_FRAME_BYTES: rd_val = frame_bytes_ff;
        spp_pkg::OFS_CHAN_SEL: rd_val = 32'(chan_sel_ff);
        spp_pkg::OFS_PKT_LEN: rd_val = 32'(pkt_len_ff);
        spp_pkg::OFS_PKT_GAP: rd_val = gap_ff;
        spp_pkg::OFS_HOLDOFF: rd_val = holdoff_ff;
        spp_pkg::OFS_RATE: rd_val = rate_ff;
        spp_pkg::OFS_RESERVE: rd_val = 32'(reserve_ff);
        spp_pkg::OFS_MULT: rd_val = 32'(mult_ff);
        // R8: ticks per second
        spp_pkg::OFS_TICK_FREQ: rd_val = spp_pkg::TICK_FREQ_HZ;
        spp_pkg::OFS_CTRL: rd_val = {31'h00000000, chunk_en_ff};
        spp_pkg::OFS_POOL: rd_val = pool_ff;
        spp_pkg::OFS_PERIOD_RESENDS: rd_val = resv_ff;
        default: nxt_rresp = spp_pkg::RESP_SLVERR;
      endcase
      nxt_rdata = rd_val;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      pkt_len_ff <= spp_pkg::PKT_LEN_RST;
      gap_ff <= spp_pkg::GAP_RST;
      holdoff_ff <= spp_pkg::HOLDOFF_RST;
      reserve_ff <= spp_pkg::RESERVE_RST;
      mult_ff <= spp_pkg::MULT_RST;
      chunk_en_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= 2'h0;
      rvalid_ff <= 1'b0;
      rresp_ff <= 2'h0;
      rdata_ff <= 32'h00000000;
    end else begin
      pkt_len_ff <= nxt_pkt_len;
      gap_ff <= nxt_gap;
      holdoff_ff <= nxt_holdoff;
      reserve_ff <= nxt_reserve;
      mult_ff <= nxt_mult;
      chunk_en_ff <= nxt_chunk_en;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rresp_ff <= nxt_rresp;
      rdata_ff <= nxt_rdata;
    end
  end

  // R6: payload room after header overhead
  assign chunk = pkt_len_ff - spp_pkg::HDR_OVERHEAD;
  assign accept = (state_ff == spp_pkg::ST_IDLE) && frame_start_i;
  assign hs = (state_ff == spp_pkg::ST_SEND) && pkt_ready_i;
  assign frame_done = hs && (kind_ff == spp_pkg::KIND_TRAILER);
  assign timer_start = accept || (hs && !frame_done);
  assign pkt_valid_o = state_ff == spp_pkg::ST_SEND;
  assign pkt_kind_o = kind_ff;
  assign pkt_bytes_o = bytes_ff;
  assign frame_busy_o = state_ff != spp_pkg::ST_IDLE;

  // one timer serves hold-off and gap since they never overlap
  // the count follows the state, as the timer compares against it every cycle
  spp_tick_timer u_timer (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .start_i(timer_start),
    .ticks_i((state_ff == spp_pkg::ST_SEND || state_ff == spp_pkg::ST_GAP) ? gap_ff : holdoff_ff),
    .done_o(timer_done)
  );

  // packet sequencer; a frame start while busy is ignored
  always_comb begin
    nxt_state = state_ff;
    nxt_kind = kind_ff;
    nxt_bytes = bytes_ff;
    nxt_remain = remain_ff;
    nxt_pkts = pkts_ff;
    nxt_last_pkts = last_pkts_ff;
    unique case (state_ff)
      spp_pkg::ST_IDLE: if (accept) begin
        nxt_state = spp_pkg::ST_HOLD;
        nxt_remain = frame_bytes_ff;
        nxt_pkts = 32'h00000000;
      end
      // R9: hold-off before the leader
      spp_pkg::ST_HOLD: if (timer_done) begin
        nxt_state = spp_pkg::ST_SEND;
        nxt_kind = spp_pkg::KIND_LEADER;
        nxt_bytes = 16'h0000;
      end
      spp_pkg::ST_SEND: if (pkt_ready_i) begin
        nxt_pkts = pkts_ff + 32'h00000001;
        if (frame_done) begin
          nxt_state = spp_pkg::ST_IDLE;
          nxt_last_pkts = nxt_pkts;
        end else begin
          nxt_state = spp_pkg::ST_GAP;
        end
      end
      // R7: gap between packets
      spp_pkg::ST_GAP: if (timer_done) begin
        nxt_state = spp_pkg::ST_SEND;
        // R4: leader, payloads, then trailer
        if (kind_ff == spp_pkg::KIND_LEADER || remain_ff != 32'h00000000) begin
          nxt_kind = spp_pkg::KIND_PAYLOAD;
          // R5: last payload may be short
          nxt_bytes = (remain_ff < 32'(chunk)) ? remain_ff[15:0] : chunk;
          nxt_remain = remain_ff - 32'(nxt_bytes);
        end else begin
          nxt_kind = spp_pkg::KIND_TRAILER;
          nxt_bytes = 16'h0000;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      state_ff <= spp_pkg::ST_IDLE;
      kind_ff <= spp_pkg::KIND_LEADER;
      bytes_ff <= 16'h0000;
      remain_ff <= 32'h00000000;
      pkts_ff <= 32'h00000000;
      last_pkts_ff <= 32'h00000000;
    end else begin
      state_ff <= nxt_state;
      kind_ff <= nxt_kind;
      bytes_ff <= nxt_bytes;
      remain_ff <= nxt_remain;
      pkts_ff <= nxt_pkts;
      last_pkts_ff <= nxt_last_pkts;
    end
  end

  // R11: rate = length * tick rate / (length + gap)
  // R12: one byte per tick
  spp_divider u_rate (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .start_i(!rate_busy),
    .num_i(W'(pkt_len_ff) * W'(spp_pkg::TICK_FREQ_HZ)),
    .den_i(W'(pkt_len_ff) + W'(gap_ff)),
    .busy_o(rate_busy),
    .done_o(rate_done),
    .quo_o(rate_q)
  );

  // R13: reserve resends per period from last frame's packet count
  spp_divider u_resv (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .start_i(!res_busy),
    .num_i(W'(last_pkts_ff) * W'(reserve_ff)),
    .den_i(W'(spp_pkg::PCT_FULL)),
    .busy_o(res_busy),
    .done_o(res_done),
    .quo_o(res_q)
  );

  // frame period is the last frame's duration; an idle stretch that long credits too
  // R17: idle period credit
  assign idle_credit = !frame_busy_o && (period_ff != 32'h00000000) && (idle_ff >= period_ff);
  // R16: unused reserve returns to the pool
  // R21: a reserve lowered mid-period must not wrap the pool below zero
  assign credit = (33'(pool_ff) + 33'(resv_ff) < 33'(used_ff)) ? 33'h000000000
    : 33'(pool_ff) + 33'(resv_ff) - 33'(used_ff);

  // resend accounting: reserve first, then pool, else refuse
  always_comb begin
    nxt_run = frame_busy_o ? run_ff + 32'h00000001 : 32'h00000000;
    nxt_period = frame_done ? run_ff + 32'h00000001 : period_ff;
    nxt_idle = (frame_busy_o || idle_credit) ? 32'h00000000 : idle_ff + 32'h00000001;
    nxt_pool = pool_ff;
    nxt_used = used_ff;
    nxt_grant = 1'b0;
    nxt_unav = 1'b0;
    nxt_pool_init = pool_init_ff;
    if (frame_done || idle_credit) begin
      // R21: saturate at capacity
      nxt_pool = (credit > 33'(cap_ff)) ? cap_ff : credit[31:0];
      nxt_used = 32'h00000000;
    end else if (resend_req_i) begin
      if (used_ff < resv_ff) begin
        nxt_used = used_ff + 32'h00000001;
        nxt_grant = 1'b1;
      end else if (pool_ff != 32'h00000000) begin
        // R16: overuse drawn from pool
        nxt_pool = pool_ff - 32'h00000001;
        nxt_grant = 1'b1;
      end else begin
        // R18: nothing left to cover it
        nxt_unav = 1'b1;
      end
    end
    // R15: pool starts full once capacity is known
    if (pool_init_ff && res_done) begin
      nxt_pool = cap_ff;
      nxt_pool_init = 1'b0;
    end
  end

  assign resend_grant_o = grant_ff;
  assign resend_unavail_o = unav_ff;

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      rate_ff <= 32'h00000000;
      resv_ff <= 32'h00000000;
      cap_ff <= 32'h00000000;
      pool_ff <= 32'h00000000;
      used_ff <= 32'h00000000;
      run_ff <= 32'h00000000;
      period_ff <= 32'h00000000;
      idle_ff <= 32'h00000000;
      pool_init_ff <= 1'b1;
      grant_ff <= 1'b0;
      unav_ff <= 1'b0;
    end else begin
      if (rate_done) rate_ff <= rate_q[31:0];
      if (res_done) resv_ff <= res_q[31:0];
      // R14: capacity = multiplier times reserve
      cap_ff <= 32'(resv_ff[15:0] * mult_ff);
      pool_ff <= nxt_pool;
      used_ff <= nxt_used;
      run_ff <= nxt_run;
      period_ff <= nxt_period;
      idle_ff <= nxt_idle;
      pool_init_ff <= nxt_pool_init;
      grant_ff <= nxt_grant;
      unav_ff <= nxt_unav;
    end
  end

  // checks on the stream, register and resend logic
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  leader_first_a: assert property ((state_ff == spp_pkg::ST_HOLD && timer_done)
    |=> pkt_valid_o && pkt_kind_o == spp_pkg::KIND_LEADER) else $error("frame did not open with leader"); // R4
  trailer_last_a: assert property ((pkt_valid_o && pkt_kind_o == spp_pkg::KIND_TRAILER)
    |-> remain_ff == 32'h00000000) else $error("trailer sent with data left"); // R4
  payload_size_a: assert property ((pkt_valid_o && pkt_kind_o == spp_pkg::KIND_PAYLOAD)
    |-> pkt_bytes_o <= pkt_len_ff - 16'h0024) else $error("payload exceeds packet length less 36"); // R6
  gap_wait_a: assert property ((hs && !frame_done && gap_ff > 32'h0000000D)
    |=> !pkt_valid_o ##1 !pkt_valid_o) else $error("gap shorter than programmed"); // R7
  holdoff_wait_a: assert property ((accept && holdoff_ff > 32'h0000000D)
    |=> !pkt_valid_o ##1 !pkt_valid_o ##1 !pkt_valid_o) else $error("hold-off too short"); // R9
  tick_freq_a: assert property ((rd_go && s_axi_araddr_i == spp_pkg::OFS_TICK_FREQ)
    |=> s_axi_rdata_o == 32'h07735940) else $error("tick frequency read wrong"); // R8
  chan_refuse_a: assert property ((wr_go && s_axi_awaddr_i == spp_pkg::OFS_CHAN_SEL && s_axi_wstrb_i[0]
    && s_axi_wdata_i[7:0] != 8'h00) |=> s_axi_bresp_o == spp_pkg::RESP_SLVERR) else $error("channel not zero"); // R3
  pool_cap_a: assert property ((frame_done || idle_credit) |=> pool_ff <= $past(cap_ff))
    else $error("pool above capacity"); // R21
  unavail_a: assert property ((resend_req_i && !frame_done && !idle_credit && !(pool_init_ff && res_done))
    |=> resend_unavail_o == ($past(used_ff) >= $past(resv_ff) && $past(pool_ff) == 32'h00000000))
    else $error("unavailable answer wrong"); // R18
  frame_done_c: cover property (frame_done);
  unavail_c: cover property (resend_unavail_o);
  idle_credit_c: cover property (idle_credit);
endmodule // spp_pacer

// [logic/spp_tick_timer.sv]
// counts elapsed time in ns so 8 ns ticks need no fast clock
module spp_tick_timer (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic start_i,
  input wire logic [31:0] ticks_i,
  output logic done_o
);
  logic [39:0] elapsed_ff;
  logic [39:0] nxt_elapsed;
  logic [39:0] target;

  assign target = 40'(ticks_i) * 40'(spp_pkg::TICK_NS);
  // a least time: done only once the full interval has passed
  assign done_o = elapsed_ff >= target;

  // restart on start, freeze once done so it cannot wrap
  always_comb begin
    nxt_elapsed = elapsed_ff;
    if (start_i) begin
      nxt_elapsed = 40'h0000000000;
    end else if (!done_o) begin
      nxt_elapsed = elapsed_ff + 40'(spp_pkg::CLK_PERIOD_NS);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      elapsed_ff <= 40'h0000000000;
    end else begin
      elapsed_ff <= nxt_elapsed;
    end
  end
endmodule // spp_tick_timer

// [pkg/spp_pkg.sv]
package spp_pkg;
  // timing base: system clock period and the 8 ns stream tick
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned TICK_NS = 8;
  localparam logic [31:0] TICK_FREQ_HZ = 32'(1000000000 / TICK_NS);

  // packet sizing
  localparam logic [15:0] HDR_OVERHEAD = 16'h0024;
  localparam logic [15:0] PKT_LEN_MIN = 16'h0025;
  localparam logic [7:0] PCT_FULL = 8'h64;
  localparam int unsigned DIV_W = 48;

  // register byte offsets
  localparam logic [7:0] OFS_FRAME_BYTES = 8'h00;
  localparam logic [7:0] OFS_CHAN_SEL = 8'h04;
  localparam logic [7:0] OFS_PKT_LEN = 8'h08;
  localparam logic [7:0] OFS_PKT_GAP = 8'h0C;
  localparam logic [7:0] OFS_HOLDOFF = 8'h10;
  localparam logic [7:0] OFS_RATE = 8'h14;
  localparam logic [7:0] OFS_RESERVE = 8'h18;
  localparam logic [7:0] OFS_MULT = 8'h1C;
  localparam logic [7:0] OFS_TICK_FREQ = 8'h20;
  localparam logic [7:0] OFS_CTRL = 8'h24;
  localparam logic [7:0] OFS_POOL = 8'h28;
  localparam logic [7:0] OFS_PERIOD_RESENDS = 8'h2C;

  // reset values
  localparam logic [15:0] PKT_LEN_RST = 16'h05DC;
  localparam logic [31:0] GAP_RST = 32'h00000000;
  localparam logic [31:0] HOLDOFF_RST = 32'h00000000;
  localparam logic [7:0] RESERVE_RST = 8'h05;
  localparam logic [15:0] MULT_RST = 16'h0003;
  localparam int unsigned CHUNK_EN_BIT = 0;

  // packet kinds on the stream port
  localparam logic [1:0] KIND_LEADER = 2'h0;
  localparam logic [1:0] KIND_PAYLOAD = 2'h1;
  localparam logic [1:0] KIND_TRAILER = 2'h2;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_HOLD, ST_SEND, ST_GAP} spp_state_e;
endpackage

// [testbench/spp_host_sink.sv]
// receiving host: takes every packet offered, or in slow mode one cycle in four
module spp_host_sink (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic slow_i,
  output logic pkt_ready_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] cnt_ff;
  // free running phase for the slow mode
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) cnt_ff <= 2'h0;
    else cnt_ff <= cnt_ff + 2'h1;
  end
  assign pkt_ready_o = !reset_i && (!slow_i || cnt_ff == 2'h3);
endmodule // spp_host_sink

// [testbench/stream_packet_pacer_tb_top.sv]
module stream_packet_pacer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, fst = 0, rq = 0, slow = 0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, img = 32'h0, chk = 32'h28;
  logic [31:0] rdt;
  logic [1:0] bre, rre, kind;
  logic bv, rv, awr, wr, arr, pv, pr, busy, gnt, una;
  logic [15:0] pb, lf = 16'h4332;
  logic [33:0] rd_q[$], pk_q[$];
  int err_total = 0, comparisons = 0;
  spp_pacer dut (.sys_clk_i(clk), .reset_i(rst), .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv),
    .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wr), .s_axi_bresp_o(bre), .s_axi_bvalid_o(bv), .s_axi_bready_i(bry),
    .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rdt),
    .s_axi_rresp_o(rre), .s_axi_rvalid_o(rv), .s_axi_rready_i(rry), .frame_start_i(fst),
    .image_bytes_i(img), .chunk_bytes_i(chk), .pkt_valid_o(pv), .pkt_ready_i(pr), .pkt_kind_o(kind),
    .pkt_bytes_o(pb), .frame_busy_o(busy), .resend_req_i(rq), .resend_grant_o(gnt), .resend_unavail_o(una));
  spp_host_sink host (.sys_clk_i(clk), .reset_i(rst), .slow_i(slow), .pkt_ready_o(pr));
  always #50 clk = ~clk;
  function automatic logic [15:0] lfsr();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction
  task automatic close_out();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // a wait that ran out of its bound ends the run
  task automatic limit(input int n);
    if (n >= 5000) begin
      err_total++;
      close_out();
    end
  endtask
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    awa <= a; wd <= d; awv <= 1; wv <= 1; bry <= 1;
    do begin @(posedge clk); n++; end while (awr !== 1'b1 && n < 5000);
    awv <= 0; wv <= 0;
    do begin @(posedge clk); n++; end while (bv !== 1'b1 && n < 5000);
    limit(n);
    check("bresp", {32'h0, bre}, {32'h0, r});
  endtask
  // the expected word is noted first, the monitor compares it when it arrives
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    int n;
    n = 0;
    rd_q.push_back({spp_pkg::RESP_OKAY, e});
    ara <= a; arv <= 1; rry <= 1;
    do begin @(posedge clk); n++; end while (arr !== 1'b1 && n < 5000);
    arv <= 0;
    do begin @(posedge clk); n++; end while (rv !== 1'b1 && n < 5000);
    limit(n);
  endtask
  // monitor: pops the oldest note at each read answer and each packet taken
  always @(posedge clk) begin
    if (rv === 1'b1 && rry === 1'b1 && rd_q.size() > 0) check("rdata", {rre, rdt}, rd_q.pop_front());
    if (pv === 1'b1 && pr === 1'b1 && pk_q.size() > 0) check("packet", {16'h0, kind, pb}, pk_q.pop_front());
  end
  initial begin
    int n, rem, tot;
    logic [15:0] t;
    repeat (4) @(posedge clk);
    rst <= 0;
    // reserve divider needs about fifty cycles after reset
    repeat (60) @(posedge clk);
    rd(spp_pkg::OFS_PKT_LEN, 32'(spp_pkg::PKT_LEN_RST));
    rd(spp_pkg::OFS_RESERVE, 32'(spp_pkg::RESERVE_RST));
    rd(spp_pkg::OFS_MULT, 32'(spp_pkg::MULT_RST));
    rd(spp_pkg::OFS_TICK_FREQ, spp_pkg::TICK_FREQ_HZ);
    rd(spp_pkg::OFS_RATE, spp_pkg::TICK_FREQ_HZ);
    bus_wr(spp_pkg::OFS_CHAN_SEL, 32'h1, spp_pkg::RESP_SLVERR);
    bus_wr(spp_pkg::OFS_CHAN_SEL, 32'h0, spp_pkg::RESP_OKAY);
    bus_wr(8'h30, 32'h1, spp_pkg::RESP_SLVERR);
    bus_wr(spp_pkg::OFS_PKT_LEN, 32'h24, spp_pkg::RESP_SLVERR);
    // short length stands for path limit
    bus_wr(spp_pkg::OFS_PKT_LEN, 32'h88, spp_pkg::RESP_OKAY);
    bus_wr(spp_pkg::OFS_RESERVE, 32'h65, spp_pkg::RESP_SLVERR);
    bus_wr(spp_pkg::OFS_RESERVE, 32'h0, spp_pkg::RESP_OKAY);
    // three frames: plain, chunked with a stalling host, empty
    for (int f = 0; f < 3; f++) begin
      t = lfsr();
      bus_wr(spp_pkg::OFS_PKT_GAP, {27'h0, t[4:0]}, spp_pkg::RESP_OKAY);
      bus_wr(spp_pkg::OFS_HOLDOFF, {27'h0, t[9:5]}, spp_pkg::RESP_OKAY);
      bus_wr(spp_pkg::OFS_CTRL, 32'(f == 1), spp_pkg::RESP_OKAY);
      img <= (f == 2) ? 32'h0 : 32'(150 + t[15:8]);
      slow <= (f == 1);
      tot = (f == 2) ? 0 : 150 + t[15:8] + (f == 1 ? 40 : 0);
      // payloads carry at most packet length less 36 bytes, the last one the rest
      pk_q.push_back({16'h0, spp_pkg::KIND_LEADER, 16'h0});
      rem = tot;
      do begin
        n = (rem > 100) ? 100 : rem;
        pk_q.push_back({16'h0, spp_pkg::KIND_PAYLOAD, 16'(n)});
        rem -= n;
      end while (rem != 0);
      pk_q.push_back({16'h0, spp_pkg::KIND_TRAILER, 16'h0});
      fst <= 1;
      @(posedge clk);
      fst <= 0;
      // a resend asked while busy is clear of any period-end edge, where it would be dropped
      rq <= (f == 2);
      @(posedge clk);
      rq <= 0;
      @(posedge clk);
      // with no reserve and an empty pool a resend is refused
      check("unavail", {33'h0, una}, {33'h0, f == 2});
      check("grant", {33'h0, gnt}, 34'h000000000);
      n = 0;
      do begin @(posedge clk); n++; end while ((busy !== 1'b0 || pk_q.size() != 0) && n < 5000);
      limit(n);
      rd(spp_pkg::OFS_FRAME_BYTES, 32'(tot));
      // the rate divider reruns on its own; two full runs pick up the new gap
      repeat (100) @(posedge clk);
      rd(spp_pkg::OFS_RATE, 32'((64'h88 * spp_pkg::TICK_FREQ_HZ) / (64'h88 + t[4:0])));
    end
    rd(spp_pkg::OFS_PERIOD_RESENDS, 32'h0);
    rd(spp_pkg::OFS_POOL, 32'h0);
    repeat (2) @(posedge clk);
    close_out();
  end
endmodule // stream_packet_pacer_tb_top
